// file: hdl/autoneg_next_page_ability_regs.sv
// next page ability, 10base-t1 advertisement and forced mode registers
// assumes mdio frame logic presents one-cycle read/write strobes on core_clk
`timescale 1ns/10ps
`include "an_np_defs.svh"
module autoneg_next_page_ability_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic negotiationReset,
	// register access from mdio frame logic
	input wire logic [4:0] devAddr,
	input wire logic [15:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire an_np_pkg::word_t writeData,
	output an_np_pkg::word_t readData,
	output logic readValid,
	// received next page from arbitration logic
	input wire logic partner_more_pages_flag,
	input wire logic partner_page_acknowledge,
	input wire logic partner_page_encoding,
	input wire logic partner_comply_acknowledge,
	input wire logic partner_page_sync_toggle,
	input wire an_np_pkg::code_t partner_page_code_field,
	input wire an_np_pkg::word_t partner_free_field_one,
	input wire an_np_pkg::word_t partner_free_field_two,
	// partner base page bits
	input wire logic partner_long_reach_ability_mirror,
	input wire logic partner_energy_saving_mirror,
	input wire logic partner_high_level_ability_mirror,
	input wire logic partner_high_level_request_mirror,
	input wire logic partner_short_reach_full_duplex,
	input wire logic partner_short_reach_half_duplex,
	// main advertisement register shared bits
	input wire logic mainAdvWrite,
	input wire logic mainLongReachData,
	input wire logic mainHighAbilityData,
	input wire logic mainHighRequestData,
	output logic local_long_reach_ability,
	output logic local_high_level_ability,
	output logic local_high_level_request,
	// strap pins
	input wire logic strapHighAbility,
	input wire logic strapHighRequest,
	// forced mode
	input wire logic negotiation_enable,
	output logic forcedOperation
);
	an_np_pkg::word_t heldMid;
	an_np_pkg::word_t heldHigh;
	an_np_pkg::word_t next_readData;
	an_np_pkg::reg_sel_t sel;
	logic [1:0] strapMeta;
	logic [1:0] strapSync;
	logic strapLoaded;
	logic forced_operation_bit;
	logic next_readValid;
	logic next_longReach;
	logic next_highAbility;
	logic next_highRequest;
	logic next_strapLoaded;
	logic next_forcedBit;
	logic next_forcedOperation;
	logic lowRead;
	logic softReset;

	function automatic an_np_pkg::reg_sel_t decode(input logic [4:0] dev, input logic [15:0] addr);
		decode = an_np_pkg::SEL_NONE;
		if (dev == `DEV_ADDR_AN) begin
			case (addr)
				`OFF_PARTNER_NP_LOW: decode = an_np_pkg::SEL_NP_LOW;
				`OFF_PARTNER_NP_MID: decode = an_np_pkg::SEL_NP_MID;
				`OFF_PARTNER_NP_HIGH: decode = an_np_pkg::SEL_NP_HIGH;
				`OFF_LOCAL_T1_ADV: decode = an_np_pkg::SEL_T1_ADV;
				`OFF_PARTNER_T1_ABILITY: decode = an_np_pkg::SEL_T1_PARTNER;
				`OFF_FORCED_OP_EN: decode = an_np_pkg::SEL_FORCED;
				default: decode = an_np_pkg::SEL_NONE;
			endcase
		end
	endfunction : decode

	assign sel = decode(devAddr, regAddr);
	assign lowRead = regRead && (sel == an_np_pkg::SEL_NP_LOW);
	assign softReset = reset || negotiationReset;

	partner_page_snapshot u_snapshot (
		.core_clk(core_clk),
		.reset(softReset),
		.capture(lowRead),
		.liveMid(partner_free_field_one),
		.liveHigh(partner_free_field_two),
		.heldMid(heldMid),
		.heldHigh(heldHigh)
	);

	// read path
	always_comb begin
		next_readData = `RST_WORD;
		next_readValid = regRead;
		if (regRead) begin
			case (sel)
				an_np_pkg::SEL_NP_LOW: begin
					next_readData[`BIT_NEXT_PAGE] = partner_more_pages_flag;
					next_readData[`BIT_ACKNOWLEDGE] = partner_page_acknowledge;
					next_readData[`BIT_ENCODING] = partner_page_encoding;
					next_readData[`BIT_COMPLY_ACK] = partner_comply_acknowledge;
					next_readData[`BIT_TOGGLE] = partner_page_sync_toggle;
					next_readData[10:0] = partner_page_code_field;
				end
				an_np_pkg::SEL_NP_MID: begin
					next_readData = heldMid;
				end
				an_np_pkg::SEL_NP_HIGH: begin
					next_readData = heldHigh;
				end
				an_np_pkg::SEL_T1_ADV: begin
					next_readData[`BIT_LONG_REACH] = local_long_reach_ability;
					next_readData[`BIT_ENERGY_SAVING] = 1'b0;
					next_readData[`BIT_HIGH_ABILITY] = local_high_level_ability;
					next_readData[`BIT_HIGH_REQUEST] = local_high_level_request;
				end
				an_np_pkg::SEL_T1_PARTNER: begin
					next_readData[`BIT_LONG_REACH] = partner_long_reach_ability_mirror;
					next_readData[`BIT_ENERGY_SAVING] = partner_energy_saving_mirror;
					next_readData[`BIT_HIGH_ABILITY] = partner_high_level_ability_mirror;
					next_readData[`BIT_HIGH_REQUEST] = partner_high_level_request_mirror;
					next_readData[`BIT_SHORT_FD] = partner_short_reach_full_duplex;
					next_readData[`BIT_SHORT_HD] = partner_short_reach_half_duplex;
				end
				an_np_pkg::SEL_FORCED: begin
					next_readData[`BIT_FORCED_OP] = forced_operation_bit;
				end
				default: begin
					next_readData = `RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			readData <= `RST_WORD;
			readValid <= 1'b0;
		end else begin
			readData <= next_readData;
			readValid <= next_readValid;
		end
	end

	// strap synchroniser, not reset
	always_ff @(posedge core_clk) begin
		strapMeta <= {strapHighAbility, strapHighRequest};
		strapSync <= strapMeta;
	end

	// shared advertisement storage and forced mode
	always_comb begin
		next_longReach = local_long_reach_ability;
		next_highAbility = local_high_level_ability;
		next_highRequest = local_high_level_request;
		next_strapLoaded = 1'b1;
		next_forcedBit = forced_operation_bit;
		if (!strapLoaded) begin
			next_highAbility = strapSync[1];
			next_highRequest = strapSync[0];
		end else if (regWrite && sel == an_np_pkg::SEL_T1_ADV) begin
			next_longReach = writeData[`BIT_LONG_REACH];
			next_highAbility = writeData[`BIT_HIGH_ABILITY];
			next_highRequest = writeData[`BIT_HIGH_REQUEST];
		end else if (mainAdvWrite) begin
			next_longReach = mainLongReachData;
			next_highAbility = mainHighAbilityData;
			next_highRequest = mainHighRequestData;
		end
		if (regWrite && sel == an_np_pkg::SEL_FORCED) begin
			next_forcedBit = writeData[`BIT_FORCED_OP];
		end
		next_forcedOperation = !negotiation_enable && next_forcedBit;
	end

	always_ff @(posedge core_clk) begin
		if (softReset) begin
			local_long_reach_ability <= `RST_LONG_REACH;
			local_high_level_ability <= 1'b0;
			local_high_level_request <= 1'b0;
			strapLoaded <= 1'b0;
			forced_operation_bit <= 1'b0;
			forcedOperation <= 1'b0;
		end else begin
			local_long_reach_ability <= next_longReach;
			local_high_level_ability <= next_highAbility;
			local_high_level_request <= next_highRequest;
			strapLoaded <= next_strapLoaded;
			forced_operation_bit <= next_forcedBit;
			forcedOperation <= next_forcedOperation;
		end
	end
endmodule : autoneg_next_page_ability_regs

// file: shared/an_np_defs.svh
// register offsets, field positions, reset values of the next page ability bank
// assumes 16-bit clause 45 register addresses within management device 0x07
`ifndef AN_NP_DEFS_SVH
`define AN_NP_DEFS_SVH
`define DEV_ADDR_AN 5'h07
`define OFF_PARTNER_NP_LOW 16'h020B
`define OFF_PARTNER_NP_MID 16'h020C
`define OFF_PARTNER_NP_HIGH 16'h020D
`define OFF_LOCAL_T1_ADV 16'h020E
`define OFF_PARTNER_T1_ABILITY 16'h020F
`define OFF_FORCED_OP_EN 16'h8000
`define BIT_NEXT_PAGE 15
`define BIT_ACKNOWLEDGE 14
`define BIT_ENCODING 13
`define BIT_COMPLY_ACK 12
`define BIT_TOGGLE 11
`define BIT_LONG_REACH 15
`define BIT_ENERGY_SAVING 14
`define BIT_HIGH_ABILITY 13
`define BIT_HIGH_REQUEST 12
`define BIT_SHORT_FD 7
`define BIT_SHORT_HD 6
`define BIT_FORCED_OP 0
`define RST_WORD 16'h0000
`define RST_LONG_REACH 1'b1
`endif

// file: shared/an_np_pkg.sv
// types shared by the next page ability register bank
// assumes nothing beyond the defs header
package an_np_pkg;
	typedef logic [15:0] word_t;
	typedef logic [10:0] code_t;
	typedef enum logic [5:0] {
		SEL_NONE = 6'h00,
		SEL_NP_LOW = 6'h01,
		SEL_NP_MID = 6'h02,
		SEL_NP_HIGH = 6'h04,
		SEL_T1_ADV = 6'h08,
		SEL_T1_PARTNER = 6'h10,
		SEL_FORCED = 6'h20
	} reg_sel_t;
endpackage : an_np_pkg

// file: hdl/partner_page_snapshot.sv
// holding copies of the partner next page middle and high words
// assumes live words come from arbitration logic on core_clk
`timescale 1ns/10ps
`include "an_np_defs.svh"
module partner_page_snapshot (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// capture request and live words
	input wire logic capture,
	input wire an_np_pkg::word_t liveMid,
	input wire an_np_pkg::word_t liveHigh,
	// held words
	output an_np_pkg::word_t heldMid,
	output an_np_pkg::word_t heldHigh
);
	an_np_pkg::word_t next_heldMid;
	an_np_pkg::word_t next_heldHigh;

	always_comb begin
		next_heldMid = heldMid;
		next_heldHigh = heldHigh;
		if (capture) begin
			next_heldMid = liveMid;
			next_heldHigh = liveHigh;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			heldMid <= `RST_WORD;
			heldHigh <= `RST_WORD;
		end else begin
			heldMid <= next_heldMid;
			heldHigh <= next_heldHigh;
		end
	end
endmodule : partner_page_snapshot

// file: bench/mdio_host_model.sv
// management host model issuing register reads and writes
// assumes strobes are taken on rising core_clk and reads answer one cycle later
`timescale 1ns/10ps
module mdio_host_model (
	// clock
	input wire logic core_clk,
	// register access
	output logic [4:0] devAddr,
	output logic [15:0] regAddr,
	output logic regRead,
	output logic regWrite,
	output an_np_pkg::word_t writeData,
	input wire an_np_pkg::word_t readData
);
	initial begin
		devAddr = 5'h07;
		regAddr = 16'hFFFF;
		regRead = 1'b0;
		regWrite = 1'b0;
		writeData = 16'h0000;
	end
	task wr(input logic [15:0] a, input an_np_pkg::word_t d);
		@(negedge core_clk);
		regAddr = a;
		writeData = d;
		regWrite = 1'b1;
		@(negedge core_clk);
		regWrite = 1'b0;
		regAddr = ~a;
		writeData = ~d;
	endtask : wr
	task rd(input logic [15:0] a, output an_np_pkg::word_t d);
		@(negedge core_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge core_clk);
		d = readData;
		regRead = 1'b0;
		regAddr = ~a;
	endtask : rd
endmodule : mdio_host_model

// file: bench/autoneg_next_page_ability_regs_properties.sv
// assertions on the next page ability register bank
// assumes a bind onto autoneg_next_page_ability_regs
`timescale 1ns/10ps
module autoneg_next_page_ability_regs_properties (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic negotiationReset,
	// register access
	input wire logic [4:0] devAddr,
	input wire logic [15:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire an_np_pkg::word_t writeData,
	input wire an_np_pkg::word_t readData,
	input wire logic readValid,
	// page words and shared bits
	input wire an_np_pkg::word_t partner_free_field_one,
	input wire an_np_pkg::word_t partner_free_field_two,
	input wire logic mainAdvWrite,
	input wire logic mainLongReachData,
	input wire logic local_long_reach_ability,
	// forced mode
	input wire logic negotiation_enable,
	input wire logic forcedOperation
);
	logic [31:0] held;
	logic [31:0] next_held;
	wire sel = devAddr == 5'h07;
	wire rdLow = regRead && sel && regAddr == 16'h020B;
	wire rdPair = regRead && sel && (regAddr == 16'h020C || regAddr == 16'h020D);
	wire rdAdv = regRead && sel && regAddr == 16'h020E;
	wire wrAdv = regWrite && sel && regAddr == 16'h020E;
	wire wrFrc = regWrite && sel && regAddr == 16'h8000;
	wire mapped = regAddr inside {[16'h020B:16'h020F], 16'h8000};
	always_comb begin
		next_held = rdLow ? {partner_free_field_two, partner_free_field_one} : held;
		if (negotiationReset) begin
			next_held = 32'h00000000;
		end
	end
	always_ff @(posedge core_clk) begin
		held <= reset ? 32'h00000000 : next_held;
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (reset);
	AST_UNMAP: assert property (regRead && !(sel && mapped) |=> readValid && readData == 16'h0000)
		else $error("unmapped read not zero");
	AST_PAIR: assert property (rdPair && !negotiationReset |=> readData == ($past(regAddr[0]) ? held[31:16] : held[15:0]))
		else $error("middle or high word not the held copy");
	AST_ADV_RSV: assert property (rdAdv |=> readData[14] == 1'b0 && readData[11:0] == 12'h000)
		else $error("advertisement fixed bits not zero");
	AST_ADV_RD: assert property (rdAdv |=> readData[15] == $past(local_long_reach_ability))
		else $error("long reach bit differs from shared storage");
	AST_ADV_WR: assert property (wrAdv && !negotiationReset |=> local_long_reach_ability == $past(writeData[15]))
		else $error("advertisement write missed shared storage");
	AST_MAIN: assert property (mainAdvWrite && !wrAdv && !negotiationReset |=> local_long_reach_ability == $past(mainLongReachData))
		else $error("main write missed shared storage");
	AST_FOFF: assert property (negotiation_enable |=> !forcedOperation)
		else $error("forced mode while negotiation enabled");
	AST_FON: assert property (wrFrc && !negotiation_enable && !negotiationReset |=> forcedOperation == $past(writeData[0]))
		else $error("forced mode does not follow written bit");
	cover property (rdLow ##[1:4] rdPair);
	cover property (wrFrc && !negotiation_enable);
	cover property (mainAdvWrite);
endmodule : autoneg_next_page_ability_regs_properties
bind autoneg_next_page_ability_regs autoneg_next_page_ability_regs_properties chk (.core_clk, .reset,
	.negotiationReset, .devAddr, .regAddr, .regRead, .regWrite, .writeData, .readData, .readValid,
	.partner_free_field_one, .partner_free_field_two, .mainAdvWrite, .mainLongReachData,
	.local_long_reach_ability, .negotiation_enable, .forcedOperation);

// file: bench/testbench.sv
// self-checking bench for the next page ability register bank
// assumes the host model drives the register strobes
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic nRst = 1'b0;
	logic enable = 1'b1;
	logic [15:0] low = 16'h0000;
	logic [5:0] bp = 6'h00;
	logic [3:0] mw = 4'h0;
	logic [1:0] straps = 2'b10;
	an_np_pkg::word_t f1 = 16'h0000;
	an_np_pkg::word_t f2 = 16'h0000;
	an_np_pkg::word_t pages [4] = '{16'hB001, 16'hB005, 16'hB006, 16'h5FFF};
	logic [4:0] devAddr;
	logic [15:0] regAddr;
	logic regRead, regWrite, readValid, longR, highA, highR, forced;
	an_np_pkg::word_t writeData, readData, got;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	always #20 core_clk = ~core_clk;
	mdio_host_model host (.core_clk, .devAddr, .regAddr, .regRead, .regWrite, .writeData, .readData);
	autoneg_next_page_ability_regs uut (.core_clk, .reset, .negotiationReset(nRst), .devAddr, .regAddr, .regRead,
		.regWrite, .writeData, .readData, .readValid, .partner_more_pages_flag(low[15]),
		.partner_page_acknowledge(low[14]), .partner_page_encoding(low[13]), .partner_comply_acknowledge(low[12]),
		.partner_page_sync_toggle(low[11]), .partner_page_code_field(low[10:0]), .partner_free_field_one(f1),
		.partner_free_field_two(f2), .partner_long_reach_ability_mirror(bp[5]), .partner_energy_saving_mirror(bp[4]),
		.partner_high_level_ability_mirror(bp[3]), .partner_high_level_request_mirror(bp[2]),
		.partner_short_reach_full_duplex(bp[1]), .partner_short_reach_half_duplex(bp[0]), .mainAdvWrite(mw[3]),
		.mainLongReachData(mw[2]), .mainHighAbilityData(mw[1]), .mainHighRequestData(mw[0]),
		.local_long_reach_ability(longR), .local_high_level_ability(highA), .local_high_level_request(highR),
		.strapHighAbility(straps[1]), .strapHighRequest(straps[0]), .negotiation_enable(enable), .forcedOperation(forced));
	task chk(input string n, input an_np_pkg::word_t e, input an_np_pkg::word_t s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task r(input logic [15:0] a, input an_np_pkg::word_t e);
		host.rd(a, got);
		chk($sformatf("reg %h", a), e, got);
	endtask : r
	task end_sim;
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		repeat (2) @(negedge core_clk);
		r(16'h020E, 16'hA000);
		r(16'h020C, 16'h0000);
		r(16'h020D, 16'h0000);
		r(16'h020F, 16'h0000);
		r(16'h8000, 16'h0000);
		foreach (pages[i]) begin
			low = pages[i];
			f1 = ~pages[i];
			f2 = pages[i];
			r(16'h020B, pages[i]);
			f1 = 16'h0F0F;
			f2 = 16'hF0F0;
			r(16'h020C, ~pages[i]);
			r(16'h020D, pages[i]);
		end
		host.wr(16'h020B, 16'h0000);
		r(16'h020B, 16'h5FFF);
		nRst = 1'b1;
		@(negedge core_clk);
		nRst = 1'b0;
		r(16'h020C, 16'h0000);
		bp = 6'h2A;
		r(16'h020F, 16'hA080);
		bp = 6'h15;
		host.wr(16'h020F, 16'hFFFF);
		r(16'h020F, 16'h5040);
		host.wr(16'h020E, 16'hFFFF);
		r(16'h020E, 16'hB000);
		chk("shared bits", 16'h0007, {13'h0000, longR, highA, highR});
		mw = 4'h9;
		@(negedge core_clk);
		mw = 4'h0;
		r(16'h020E, 16'h1000);
		host.wr(16'h8000, 16'hFFFF);
		r(16'h8000, 16'h0001);
		chk("forced", 16'h0000, {15'h0000, forced});
		enable = 1'b0;
		@(negedge core_clk);
		chk("forced", 16'h0001, {15'h0000, forced});
		host.wr(16'h8000, 16'h0000);
		chk("forced", 16'h0000, {15'h0000, forced});
		host.devAddr = 5'h01;
		r(16'h020E, 16'h0000);
		host.devAddr = 5'h07;
		straps = 2'b01;
		repeat (2) @(negedge core_clk);
		nRst = 1'b1;
		@(negedge core_clk);
		nRst = 1'b0;
		r(16'h020E, 16'h9000);
		chk("forced", 16'h0000, {15'h0000, forced});
		r(16'h0300, 16'h0000);
		end_sim;
	end
endmodule : testbench
